/* File: src/dmsd_pkg.sv */
package dmsd_pkg;

  // ----------------------------------------------------------------------
  // Instruction field layout
  // ----------------------------------------------------------------------
  localparam int IW = 24;
  localparam logic [8:0] SHIFT_IMM_PFX = 9'h01e;
  localparam logic [11:0] REG_MOVE_PFX = 12'h1a0;
  localparam logic [3:0] DREG_IMM_PFX = 4'h4;
  localparam logic [3:0] NREG_IMM_PFX = 4'h3;
  localparam logic [2:0] DM_DIRECT_PFX = 3'h4;
  localparam logic [2:0] DM_IND_PFX = 3'h3;
  localparam logic [5:0] PM_IND_PFX = 6'h14;
  localparam logic [4:0] AMF_NOP = 5'h00;

  // Shifter function codes for the logical shift.
  localparam logic [3:0] SF_HI_PASS = 4'h0;
  localparam logic [3:0] SF_HI_OR = 4'h1;
  localparam logic [3:0] SF_LO_PASS = 4'h2;
  localparam logic [3:0] SF_LO_OR = 4'h3;

  // ----------------------------------------------------------------------
  // Register file index map (6-bit: group in [5:4], register in [3:0])
  // ----------------------------------------------------------------------
  localparam logic [5:0] R_ACC_MID = 6'h0d;
  localparam logic [5:0] R_ACC_OVF = 6'h0e;
  localparam logic [5:0] R_SHIFT_LO = 6'h0f;
  localparam logic [5:0] R_SHIFT_HI = 6'h0e;
  localparam logic [5:0] R_SHIFT_IN = 6'h0b;
  localparam logic [5:0] R_ARITHMETIC_STATUS_REG = 6'h30;
  localparam logic [5:0] R_MODE_STATUS_REG = 6'h31;
  localparam logic [5:0] R_STACK_STATUS_REG = 6'h32;
  localparam logic [5:0] R_INTERRUPT_MASK_REG = 6'h33;
  localparam logic [5:0] R_INTERRUPT_CONTROL_REG = 6'h34;
  localparam logic [5:0] R_LOOP_COUNTER = 6'h35;
  localparam logic [5:0] R_PX = 6'h37;
  localparam logic [5:0] R_RX0 = 6'h38;
  localparam logic [5:0] R_TX0 = 6'h39;
  localparam logic [5:0] R_OWRCNT = 6'h3e;
  localparam logic [5:0] R_IFCLR = 6'h3f;
  localparam logic [15:0] REG_RESET = 16'h0000;

endpackage

/* File: src/dmsd_shift.sv */
`timescale 1ns/100ps
// Logical shifter: 16-bit operand referenced to upper or lower half of 32 bits.
module dmsd_shift (
  // Operand and control
  input wire logic [15:0] operand,
  input wire logic signed [7:0] amount,
  input wire logic hi_ref,
  // Result
  output logic [31:0] result
);

  logic [31:0] placed;
  logic [7:0] mag;

  // Place then shift; zero fill both ends, bits leaving are dropped.
  always_comb begin
    placed = hi_ref ? {operand, 16'h0000} : {16'h0000, operand};
    mag = amount[7] ? 8'(-amount) : 8'(amount);
    if (amount[7]) begin
      result = (mag > 8'h1f) ? 32'h0000_0000 : (placed >> mag);
    end else begin
      result = (mag > 8'h1f) ? 32'h0000_0000 : (placed << mag);
    end
  end

endmodule

/* File: src/dmsd_core.sv */
`timescale 1ns/100ps
// Contract
// - Negative logical shift moves right, zero fills left, drops low bits.
// - Shift immediate is recognised by bits 23..15 equal 000011110.
// - Function 0..3 picks upper or lower reference, plain or OR.
// - Shift amount is eight-bit signed; positive left, negative right.
// - None of these instructions alter arithmetic status flags; writes that target R_ARITHMETIC_STATUS_REG still change it.
// - Moves place source right-justified, bit 0 to bit 0.
// - Narrow to wide moves sign-extend signed and zero-fill unsigned sources.
// - Index, length, counter, extension, status, mask, control sources zero-extend.
// - Wide to narrow moves keep low bits and drop the rest.
// - Writes to the accumulator middle word sign-extend into overflow word.
// - Register move prefix 000110100000 with group and register selects.
// - Data register loads take 16 bits, others 14, sign-extended.
// - Serial receive and transmit immediate loads supply only 14 bits.
// - Data register immediate load has top prefix 0100.
// - Non-data register immediate load has top prefix 0011.
// - An N-bit destination takes the low N bits of the data field.
// - Direct memory read uses the 14-bit address in the word.
// - Indirect read uses the index, then post-modifies it.
// - Function field zero means no arithmetic beside the read.
// - One select bit picks the generator for index and modify together.
// - Program memory read: top 16 bits to register, low 8 to extension; the code reads only when the function field is zero.
module dmsd_core (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Instruction issue
  input wire logic INSTR_VALID,
  input wire logic [23:0] INSTR,
  // Data memory read
  output logic [13:0] DM_ADDR,
  output logic DM_RD,
  input wire logic [15:0] DM_RDATA,
  // Program memory read
  output logic [13:0] PM_ADDR,
  output logic PM_RD,
  input wire logic [23:0] PM_RDATA,
  // Observation
  output logic [31:0] SHIFT_RESULT,
  output logic [15:0] WB_DATA,
  output logic [5:0] WB_SEL,
  output logic WB_STB,
  output logic ALU_REQ,
  output logic ILLEGAL
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0] regs_r [0:63];
  logic [13:0] idx_r [0:7];
  logic [13:0] mod_r [0:7];
  logic [15:0] arithmetic_status_reg_r;

  // Width and signedness per selected register (local selection table).
  function automatic logic [4:0] reg_width(input logic [5:0] sel);
    if (sel[5:4] == 2'h0) begin
      reg_width = (sel == dmsd_pkg::R_ACC_OVF) ? 5'd8 : 5'd16;
    end else if (sel[5:4] == 2'h1 || sel[5:4] == 2'h2) begin
      reg_width = 5'd14;  // index, modify and length banks
    end else if (sel == dmsd_pkg::R_PX || sel == dmsd_pkg::R_ARITHMETIC_STATUS_REG) begin
      reg_width = 5'd8;
    end else if (sel == dmsd_pkg::R_RX0 || sel == dmsd_pkg::R_TX0) begin
      reg_width = 5'd16;
    end else begin
      reg_width = 5'd14;
    end
  endfunction

  // Unsigned sources zero-extend; all others sign-extend.
  function automatic logic is_unsigned(input logic [5:0] sel);
    is_unsigned = (sel[5:4] == 2'h1) || (sel[5:4] == 2'h2 && sel[3]) ||
      sel == dmsd_pkg::R_LOOP_COUNTER || sel == dmsd_pkg::R_PX || sel == dmsd_pkg::R_ARITHMETIC_STATUS_REG ||
      sel == dmsd_pkg::R_MODE_STATUS_REG || sel == dmsd_pkg::R_STACK_STATUS_REG ||
      sel == dmsd_pkg::R_INTERRUPT_MASK_REG || sel == dmsd_pkg::R_INTERRUPT_CONTROL_REG;
  endfunction

  // Extend a value of width w to 16 bits, signed or not.
  function automatic logic [15:0] extend(input logic [15:0] v, input logic [4:0] w,
                                         input logic uns);
    logic [15:0] mask;
    logic sgn;
    mask = (w >= 5'd16) ? 16'hffff : 16'((17'h1 << w) - 17'h1);
    sgn = (w == 5'd0) ? 1'b0 : v[4'(w - 5'd1)];
    extend = (v & mask) | ((uns || !sgn) ? 16'h0000 : ~mask);
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic is_shift, is_move, is_dimm, is_nimm, is_dmd, is_dmi, is_pmi;
  logic [5:0] dst_sel, src_sel;
  logic [15:0] src_val, imm_val;
  logic [2:0] ind_i, ind_m;
  logic [31:0] shift_out;

  // Load target of a memory read, held for the capture cycle.
  logic [5:0] ld_sel_r;
  // Value of the index register that an indirect access uses this cycle.
  logic [13:0] dm_addr_next;

  always_comb begin
    is_shift = INSTR[23:15] == dmsd_pkg::SHIFT_IMM_PFX && !INSTR[14] && !INSTR[13];
    is_move = INSTR[23:12] == dmsd_pkg::REG_MOVE_PFX;
    is_dimm = INSTR[23:20] == dmsd_pkg::DREG_IMM_PFX;
    is_nimm = INSTR[23:20] == dmsd_pkg::NREG_IMM_PFX;
    // Bit 20 set is the direct write form, which this block does not execute.
    is_dmd = INSTR[23:21] == dmsd_pkg::DM_DIRECT_PFX && !INSTR[20];
    is_dmi = INSTR[23:21] == dmsd_pkg::DM_IND_PFX && INSTR[19:18] == 2'h0;
    is_pmi = INSTR[23:18] == dmsd_pkg::PM_IND_PFX;
  end

  // Selection table: group and register fields form one 6-bit index.
  always_comb begin
    dst_sel = 6'h00;
    src_sel = {INSTR[9:8], INSTR[3:0]};
    if (is_move) begin
      dst_sel = {INSTR[11:10], INSTR[7:4]};
    end else if (is_dimm) begin
      dst_sel = {2'h0, INSTR[3:0]};
    end else if (is_nimm) begin
      dst_sel = {INSTR[19:18], INSTR[3:0]};
    end else if (is_dmd) begin
      dst_sel = {INSTR[19:18], INSTR[3:0]};
    end else begin
      dst_sel = {2'h0, INSTR[7:4]};
    end
  end

  // Move source and immediate value.
  always_comb begin
    src_val = extend(regs_r[src_sel], reg_width(src_sel), is_unsigned(src_sel));
    // Immediate: low N bits of the right-justified field, sign-extended.
    if (is_dimm) begin
      imm_val = INSTR[19:4];
    end else begin
      imm_val = extend({2'h0, INSTR[17:4]}, 5'd14, 1'b0);
    end
    ind_i = {INSTR[20] | is_pmi, INSTR[3:2]};
    ind_m = {INSTR[20] | is_pmi, INSTR[1:0]};
  end

  dmsd_shift u_shift (
    .operand(regs_r[dmsd_pkg::R_SHIFT_IN]),
    .amount(INSTR[7:0]),
    .hi_ref(!INSTR[12]),
    .result(shift_out)
  );

  // ----------------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------------
  logic [15:0] wr_val;
  logic [5:0] wr_sel;
  logic wr_en, bad;

  // Pick the value and target of this cycle's register write.
  always_comb begin
    wr_val = 16'h0000;
    wr_sel = dst_sel;
    wr_en = 1'b0;
    bad = 1'b0;
    if (INSTR_VALID) begin
      if (is_move) begin
        bad = src_sel == dmsd_pkg::R_OWRCNT || src_sel == dmsd_pkg::R_IFCLR ||
          dst_sel == dmsd_pkg::R_STACK_STATUS_REG;
        wr_en = !bad;
        wr_val = src_val;
      end else if (is_dimm || is_nimm) begin
        bad = dst_sel == dmsd_pkg::R_STACK_STATUS_REG;
        wr_en = !bad;
        wr_val = imm_val;
      end
    end
  end

  // Register file update; truncation is done by masking the written value to the register width.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      for (int k = 0; k < 64; k++) begin
        regs_r[k] <= dmsd_pkg::REG_RESET;
      end
    end else begin
      if (wr_en) begin
        regs_r[wr_sel] <= wr_val & extend(16'hffff, reg_width(wr_sel), 1'b1);
        if (wr_sel == dmsd_pkg::R_ACC_MID) begin
          regs_r[dmsd_pkg::R_ACC_OVF] <= {8'h00, {8{wr_val[15]}}};
        end
      end
      if (DM_RD) begin
        regs_r[ld_sel_r] <= DM_RDATA & extend(16'hffff, reg_width(ld_sel_r), 1'b1);
        if (ld_sel_r == dmsd_pkg::R_ACC_MID) begin
          regs_r[dmsd_pkg::R_ACC_OVF] <= {8'h00, {8{DM_RDATA[15]}}};
        end
      end
      if (PM_RD) begin
        regs_r[ld_sel_r] <= PM_RDATA[23:8] & extend(16'hffff, reg_width(ld_sel_r), 1'b1);
        regs_r[dmsd_pkg::R_PX] <= {8'h00, PM_RDATA[7:0]};
        if (ld_sel_r == dmsd_pkg::R_ACC_MID) begin
          regs_r[dmsd_pkg::R_ACC_OVF] <= {8'h00, {8{PM_RDATA[23]}}};
        end
      end
      if (INSTR_VALID && is_shift) begin
        regs_r[dmsd_pkg::R_SHIFT_HI] <= (INSTR[11] ? regs_r[dmsd_pkg::R_SHIFT_HI] : 16'h0000) |
          shift_out[31:16];
        regs_r[dmsd_pkg::R_SHIFT_LO] <= (INSTR[11] ? regs_r[dmsd_pkg::R_SHIFT_LO] : 16'h0000) |
          shift_out[15:0];
      end
    end
  end

  // The status copy is never written; moves and loads to R_ARITHMETIC_STATUS_REG write only regs_r.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      arithmetic_status_reg_r <= dmsd_pkg::REG_RESET;
    end else begin
      arithmetic_status_reg_r <= arithmetic_status_reg_r;
    end
  end

  // Memory read requests and index post-modify.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      DM_RD <= 1'b0;
      PM_RD <= 1'b0;
      DM_ADDR <= 14'h0000;
      PM_ADDR <= 14'h0000;
      ld_sel_r <= 6'h00;
      for (int k = 0; k < 8; k++) begin
        idx_r[k] <= 14'h0000;
        mod_r[k] <= 14'h0001;
      end
    end else begin
      DM_RD <= INSTR_VALID && (is_dmd || is_dmi) && dst_sel != dmsd_pkg::R_STACK_STATUS_REG;
      PM_RD <= INSTR_VALID && is_pmi && INSTR[17:13] == dmsd_pkg::AMF_NOP;
      ld_sel_r <= dst_sel;
      if (INSTR_VALID && is_dmd) begin
        DM_ADDR <= INSTR[17:4];
      end else if (INSTR_VALID && is_dmi) begin
        DM_ADDR <= idx_r[ind_i];
        idx_r[ind_i] <= 14'(idx_r[ind_i] + mod_r[ind_m]);
      end
      if (INSTR_VALID && is_pmi) begin
        PM_ADDR <= idx_r[ind_i];
        idx_r[ind_i] <= 14'(idx_r[ind_i] + mod_r[ind_m]);
      end
      if (wr_en && wr_sel[5:4] == 2'h1) begin
        idx_r[wr_sel[2:0]] <= wr_val[13:0];
      end
      if (wr_en && wr_sel[5:3] == 3'h4) begin
        mod_r[wr_sel[2:0]] <= wr_val[13:0];
      end
    end
  end

  // Observation outputs, all registered.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      SHIFT_RESULT <= 32'h0000_0000;
      WB_DATA <= 16'h0000;
      WB_SEL <= 6'h00;
      WB_STB <= 1'b0;
      ALU_REQ <= 1'b0;
      ILLEGAL <= 1'b0;
    end else begin
      // The result field holds between shifts so that the OR form can merge into it.
      if (INSTR_VALID && is_shift) begin
        SHIFT_RESULT <= (INSTR[11] ? SHIFT_RESULT : 32'h0000_0000) | shift_out;
      end
      WB_DATA <= wr_val;
      WB_SEL <= wr_sel;
      WB_STB <= wr_en;
      ALU_REQ <= INSTR_VALID && (is_dmi || is_pmi) && INSTR[17:13] != dmsd_pkg::AMF_NOP;
      ILLEGAL <= bad;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_stat_kept: assert property (@(posedge MCLK) disable iff (SRST)
    !$changed(arithmetic_status_reg_r)) else $error("status changed");
  a_stack_status_reg_ro: assert property (@(posedge MCLK) disable iff (SRST)
    WB_STB |-> WB_SEL != dmsd_pkg::R_STACK_STATUS_REG) else $error("stack status written");
  a_acc_ext: assert property (@(posedge MCLK) disable iff (SRST)
    (wr_en && wr_sel == dmsd_pkg::R_ACC_MID && !DM_RD && !PM_RD) |=>
    regs_r[dmsd_pkg::R_ACC_OVF][7:0] == {8{$past(wr_val[15])}})
    else $error("overflow word not extended");
  a_px_load: assert property (@(posedge MCLK) disable iff (SRST)
    PM_RD |=> regs_r[dmsd_pkg::R_PX][7:0] == $past(PM_RDATA[7:0]))
    else $error("extension not loaded");
  a_dm_direct: assert property (@(posedge MCLK) disable iff (SRST)
    (INSTR_VALID && is_dmd) |=> DM_RD ##0 DM_ADDR == $past(INSTR[17:4]))
    else $error("direct address wrong");
  a_shift_right: assert property (@(posedge MCLK) disable iff (SRST)
    (INSTR_VALID && is_shift && INSTR[7] && INSTR[12:11] == 2'h2) |->
    shift_out[31:16] == 16'h0000) else $error("right shift not zero filled");
  a_dm_postmod: assert property (@(posedge MCLK) disable iff (SRST)
    (INSTR_VALID && is_dmi && !is_pmi && !(wr_en && wr_sel[5:4] == 2'h1)) |=>
    idx_r[$past(ind_i)] == 14'($past(dm_addr_next) + $past(mod_r[ind_m])))
    else $error("post modify wrong");
  assign dm_addr_next = idx_r[ind_i];
  a_imm_ext: assert property (@(posedge MCLK) disable iff (SRST)
    (INSTR_VALID && is_nimm && wr_en) |-> wr_val[15:14] == {2{INSTR[17]}})
    else $error("immediate not sign extended");

endmodule

/* File: dv/tb_dsp_move_and_shift_decode.sv */
`timescale 1ns/100ps
module tb_dsp_move_and_shift_decode;
  // ------------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------------
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic INSTR_VALID = 1'b0;
  logic [23:0] INSTR = 24'h000000;
  logic [15:0] DM_RDATA = 16'h0000;
  logic [23:0] PM_RDATA = 24'h000000;
  logic [13:0] DM_ADDR, PM_ADDR;
  logic DM_RD, PM_RD, WB_STB, ALU_REQ, ILLEGAL;
  logic [31:0] SHIFT_RESULT;
  logic [15:0] WB_DATA;
  logic [5:0] WB_SEL;
  int n_mismatch = 0;
  int check_count = 0;
  int cor [6] = '{-32, 31, -1, 32, -31, 0};
  logic [3:0] r, r2, sf;
  logic [1:0] g2, i, m;
  logic g;
  logic [15:0] v, w;
  logic [13:0] v14, p, md;
  logic [23:0] pw;
  logic [31:0] sr;
  logic signed [7:0] a;

  dmsd_core dut (
    .MCLK(MCLK), .SRST(SRST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .DM_ADDR(DM_ADDR), .DM_RD(DM_RD), .DM_RDATA(DM_RDATA),
    .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_RDATA(PM_RDATA),
    .SHIFT_RESULT(SHIFT_RESULT), .WB_DATA(WB_DATA), .WB_SEL(WB_SEL),
    .WB_STB(WB_STB), .ALU_REQ(ALU_REQ), .ILLEGAL(ILLEGAL)
  );

  // 40 MHz core clock.
  initial begin
    forever #12.5 MCLK = ~MCLK;
  end

  // ------------------------------------------------------------------
  // Encoders and expectation helpers
  // ------------------------------------------------------------------
  function automatic logic [23:0] ld_d(input logic [3:0] rr, input logic [15:0] d);
    return {dmsd_pkg::DREG_IMM_PFX, d, rr};
  endfunction

  function automatic logic [23:0] ld_n(input logic [1:0] gp, input logic [3:0] rr,
                                       input logic [13:0] d);
    return {dmsd_pkg::NREG_IMM_PFX, gp, d, rr};
  endfunction

  function automatic logic [23:0] mv(input logic [5:0] d, input logic [5:0] s);
    return {dmsd_pkg::REG_MOVE_PFX, d[5:4], s[5:4], d[3:0], s[3:0]};
  endfunction

  // Reference shifter; a magnitude past 31 leaves nothing in the field.
  function automatic logic [31:0] shexp(input logic [15:0] op, input logic hi,
                                        input logic signed [7:0] amt);
    logic [31:0] b;
    b = hi ? {op, 16'h0000} : {16'h0000, op};
    if (amt >= 0) return (amt > 31) ? 32'h00000000 : b << amt;
    return (amt < -31) ? 32'h00000000 : b >> (-amt);
  endfunction

  // ------------------------------------------------------------------
  // Bench tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Issues one word; returns just after the taking edge, when answers stand.
  task automatic exec(input logic [23:0] ins);
    INSTR = ins;
    INSTR_VALID = 1'b1;
    @(posedge MCLK);
    #2;
  endtask

  // Serves the memory data through the capture cycle, then scrambles the bus
  // so a late sample cannot see a stale but correct value.
  task automatic feed(input logic [15:0] d, input logic [23:0] pd);
    INSTR_VALID = 1'b0;
    DM_RDATA = d;
    PM_RDATA = pd;
    @(posedge MCLK);
    #2;
    DM_RDATA = ~d;
    PM_RDATA = ~pd;
  endtask

  task automatic mvchk(input logic [5:0] d, input logic [5:0] s, input logic [15:0] e);
    exec(mv(d, s));
    chk(WB_STB, 1);
    chk(WB_SEL, d);
    chk(WB_DATA, e);
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run through the same report.
  initial begin
    #250000;
    n_mismatch++;
    final_report();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(36271));
    repeat (2) @(posedge MCLK);
    #2;
    SRST = 1'b0;
    mvchk(6'h00, dmsd_pkg::R_ARITHMETIC_STATUS_REG, 16'h0000);
    for (int k = 0; k < 24; k++) begin
      r = 4'($urandom_range(7));
      r2 = 4'($urandom_range(7));
      {g, i, m, g2} = 7'($urandom);
      v = 16'($urandom);
      v14 = 14'($urandom);
      // Data register load, then through a narrow unsigned index and back.
      exec(ld_d(r, v));
      chk(WB_SEL, {2'b00, r});
      chk(WB_DATA, v);
      exec(mv({2'b01, 1'b0, g, i}, {2'b00, r}));
      mvchk({2'b00, r2}, {2'b01, 1'b0, g, i}, {2'b00, v[13:0]});
      // Signed narrow sources widen with their sign.
      exec(ld_n(2'b10, {1'b0, g, m}, v14));
      mvchk({2'b00, r2}, {2'b10, 1'b0, g, m}, {{2{v14[13]}}, v14});
      exec(ld_n(2'b11, dmsd_pkg::R_RX0[3:0], v14));
      mvchk({2'b00, r2}, dmsd_pkg::R_RX0, {{2{v14[13]}}, v14});
      exec(ld_d(dmsd_pkg::R_ACC_MID[3:0], v));
      mvchk({2'b00, r2}, dmsd_pkg::R_ACC_OVF, {16{v[15]}});
      // Back-to-back shifts: a plain one, then one merged by OR.
      exec(ld_d(dmsd_pkg::R_SHIFT_IN[3:0], v));
      sf = {2'b00, g2[0], 1'b0};
      a = (k < 6) ? 8'(cor[k]) : 8'(int'($urandom_range(80)) - 40);
      exec({dmsd_pkg::SHIFT_IMM_PFX, sf, 3'b000, a});
      sr = shexp(v, ~sf[1], a);
      chk(SHIFT_RESULT, sr);
      sf = {2'b00, g2[1], 1'b1};
      a = 8'(int'($urandom_range(80)) - 40);
      exec({dmsd_pkg::SHIFT_IMM_PFX, sf, 3'b000, a});
      sr = sr | shexp(v, ~sf[1], a);
      chk(SHIFT_RESULT, sr);
      // Indirect read twice: the second address is the post-modified index.
      p = 14'($urandom);
      md = 14'($urandom);
      w = 16'($urandom);
      exec(ld_n(2'b01, {1'b0, g, i}, p));
      exec(ld_n(2'b10, {1'b0, g, m}, md));
      exec({3'b011, g, 2'b00, dmsd_pkg::AMF_NOP, 5'h00, r, i, m});
      chk(DM_ADDR, p);
      chk({DM_RD, ALU_REQ}, 2'b10);
      feed(w, 24'h000000);
      mvchk({2'b00, r2}, {2'b00, r}, w);
      exec({3'b011, g, 2'b00, 5'h01, 5'h00, r, i, m});
      chk(DM_ADDR, 14'(p + md));
      chk(ALU_REQ, 1);
      feed(~w, 24'h000000);
      // Direct read from the address carried in the word.
      exec({4'b1000, 2'b00, v14, r});
      chk({DM_RD, DM_ADDR}, {1'b1, v14});
      feed(v, 24'h000000);
      mvchk({2'b00, r2}, {2'b00, r}, v);
      // Program memory read splits the word between register and extension.
      pw = 24'($urandom);
      exec(ld_n(2'b01, {2'b01, i}, p));
      exec({dmsd_pkg::PM_IND_PFX, dmsd_pkg::AMF_NOP, 5'h00, r, i, m});
      chk({PM_RD, PM_ADDR}, {1'b1, p});
      feed(16'h0000, pw);
      mvchk({2'b00, r2}, {2'b00, r}, pw[23:8]);
      mvchk({2'b00, r2}, dmsd_pkg::R_PX, {8'h00, pw[7:0]});
      // Refused directions raise the flag and write nothing.
      exec(mv({2'b00, r2}, g ? dmsd_pkg::R_IFCLR : dmsd_pkg::R_OWRCNT));
      chk({ILLEGAL, WB_STB}, 2'b10);
      exec(mv(dmsd_pkg::R_STACK_STATUS_REG, {2'b00, r}));
      chk({ILLEGAL, WB_STB}, 2'b10);
      mvchk({2'b00, r2}, dmsd_pkg::R_STACK_STATUS_REG, 16'h0000);
    end
    mvchk(6'h00, dmsd_pkg::R_ARITHMETIC_STATUS_REG, 16'h0000);
    INSTR_VALID = 1'b0;
    @(posedge MCLK);
    #2;
    final_report();
  end
endmodule
